// *** hw/adc_regs.svh ***
// Purpose: register indexes, field positions, reset values, timing counts
// Assumes: 32-bit classic Wishbone, byte address = 4 * register index
// Notes: definitions only
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

// ****************************************
// register indexes
// ****************************************
`define IDX_WIDTH 6
`define IDX_CONVERTER_CONTROL 6'h1f
`define IDX_RESULT_HIGH 6'h1e
`define IDX_RESULT_LOW 6'h1d
`define IDX_PIN_FUNCTION_CONFIG 6'h1c
`define IDX_INT_STATUS 6'h1b
`define IDX_INT_MASK 6'h1a

// ****************************************
// converter_control fields
// ****************************************
`define CTRL_CLK_MSB 7
`define CTRL_CLK_LSB 6
`define CTRL_CH_MSB 5
`define CTRL_CH_LSB 3
`define CTRL_GO_BIT 2
`define CTRL_ON_BIT 0
`define CTRL_RESET 8'h00

// ****************************************
// pin_function_config fields
// ****************************************
`define PIN_ANALOG_MSB 7
`define PIN_REF_MSB 9
`define PIN_REF_LSB 8
`define PIN_CFG_RESET 10'h000
`define LOW_REF_CHANNEL 2
`define HIGH_REF_CHANNEL 3

// ****************************************
// interrupt fields
// ****************************************
`define INT_DONE_BIT 0
`define INT_ABORT_BIT 1
`define INT_RESET 2'h0

// ****************************************
// conversion and timing
// ****************************************
`define RESULT_BITS 10
`define MAX_CHANNELS 8
`define DIV2_CYCLES 2
`define DIV8_CYCLES 8
`define DIV32_CYCLES 32
`define CLK_PERIOD_NS 100
`define RC_PERIOD_NS 4000
`define RC_DIV_CYCLES ((`RC_PERIOD_NS) / (`CLK_PERIOD_NS))
`define SAR_SETTLE_CYCLES 3

`endif

// *** hw/adc_pkg.sv ***
// Purpose: types shared by the converter control modules
// Assumes: adc_regs.svh holds every number
// Notes: none
package adc_pkg;
  `include "adc_regs.svh"

  typedef enum logic [1:0] {
    CLK_DIV2 = 2'b00,
    CLK_DIV8 = 2'b01,
    CLK_DIV32 = 2'b10,
    CLK_RC = 2'b11
  } conv_clock_type;

  typedef enum logic [1:0] {
    SAR_IDLE = 2'b00,
    SAR_SAMPLE = 2'b01,
    SAR_TRIAL = 2'b10
  } sar_phase_type;

  typedef struct packed {
    sar_phase_type phase;
    logic [`RESULT_BITS-1:0] result;
    logic [3:0] bit_idx;
    logic [1:0] settle;
    logic done;
  } sar_state_type;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } clk_gen_state_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    conv_clock_type clk_sel;
    logic [2:0] ch_sel;
    logic power_on;
    logic busy;
    logic finishing;
    logic start;
    logic abort;
    logic [`RESULT_BITS-1:0] result;
    logic [`PIN_REF_MSB:0] pin_cfg;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic comp_s1;
    logic comp_s2;
  } ctrl_state_type;
endpackage

// *** hw/conv_if.sv ***
// Purpose: link between converter control and the approximation engine
// Assumes: one clock domain
// Notes: tick paces the engine, done is a one-cycle pulse
`timescale 1ns/10ps
`include "adc_regs.svh"
interface conv_if;
  import adc_pkg::*;
  logic start;
  logic abort;
  logic tick;
  logic comp;
  logic done;
  logic busy;
  logic sampling;
  logic [`RESULT_BITS-1:0] result;
  logic [`RESULT_BITS-1:0] trial;
  modport ctrl (output start, output abort, output tick, output comp,
                input done, input busy, input sampling, input result,
                input trial);
  modport engine (input start, input abort, input tick, input comp,
                  output done, output busy, output sampling,
                  output result, output trial);
endinterface

// *** hw/conv_clock_gen.sv ***
// Purpose: conversion tick from divided system clock or internal RC clock
// Assumes: rc oscillator modelled as a fixed divide of ref_clk_in
// Notes: divided ticks stop in sleep, rc ticks keep running
`timescale 1ns/10ps
`include "adc_regs.svh"
module conv_clock_gen
  import adc_pkg::*;
#(
  parameter int RC_DIV = `RC_DIV_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire conv_clock_type clk_sel_in,
  input wire logic power_on_in,
  input wire logic sleep_in,
  output logic tick_out
);
  if (RC_DIV < 2 || RC_DIV > 256) begin : g_check
    $error("RC_DIV out of range");
  end

  clk_gen_state_type st_reg;
  clk_gen_state_type st_next;
  logic [7:0] limit;
  logic run;

  always_comb begin
    unique case (clk_sel_in)
      CLK_DIV2: limit = 8'(`DIV2_CYCLES - 1);
      CLK_DIV8: limit = 8'(`DIV8_CYCLES - 1);
      CLK_DIV32: limit = 8'(`DIV32_CYCLES - 1);
      CLK_RC: limit = 8'(RC_DIV - 1);
    endcase
    // system clock halts in sleep, only the rc source survives
    run = power_on_in && (!sleep_in || clk_sel_in == CLK_RC);
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.cnt = 8'h00;
    end else if (st_reg.cnt >= limit) begin
      st_next.cnt = 8'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_out = st_reg.tick;
endmodule

// *** hw/sar_engine.sv ***
// Purpose: sample, then resolve at most one result bit per conversion tick
// Assumes: comp is high when the input is at or above the trial code
// Notes: each trial waits a settle time so the synced comparator is fresh
`timescale 1ns/10ps
`include "adc_regs.svh"
module sar_engine
  import adc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  conv_if.engine cif
);
  sar_state_type st_reg;
  sar_state_type st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (st_reg.settle != 2'h0) begin
      st_next.settle = st_reg.settle - 2'h1;
    end
    if (cif.abort) begin
      st_next.phase = SAR_IDLE;
    end else begin
      unique case (st_reg.phase)
        SAR_IDLE: begin
          if (cif.start) begin
            st_next.phase = SAR_SAMPLE;
            st_next.result = '0;
          end
        end
        SAR_SAMPLE: begin
          if (cif.tick) begin
            st_next.phase = SAR_TRIAL;
            st_next.bit_idx = 4'(`RESULT_BITS - 1);
            st_next.settle = 2'(`SAR_SETTLE_CYCLES);
          end
        end
        SAR_TRIAL: begin
          if (cif.tick && st_reg.settle == 2'h0) begin
            st_next.result[st_reg.bit_idx] = cif.comp;
            st_next.settle = 2'(`SAR_SETTLE_CYCLES);
            if (st_reg.bit_idx == 4'h0) begin
              st_next.phase = SAR_IDLE;
              st_next.done = 1'b1;
            end else begin
              st_next.bit_idx = st_reg.bit_idx - 4'h1;
            end
          end
        end
        default: st_next.phase = SAR_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cif.done = st_reg.done;
  assign cif.busy = st_reg.phase != SAR_IDLE;
  assign cif.sampling = st_reg.phase == SAR_SAMPLE;
  assign cif.result = st_reg.result;
  assign cif.trial = (st_reg.phase == SAR_TRIAL) ?
                     (st_reg.result | (`RESULT_BITS'(1) << st_reg.bit_idx)) :
                     '0;
endmodule

// *** hw/adc_conversion_control.sv ***
// Purpose: register file and sequencing of a 10-bit SAR converter
// Assumes: classic Wishbone slave, one clock, analog front end outside
// Notes: byte address of a register is four times its index
`timescale 1ns/10ps
`include "adc_regs.svh"
module adc_conversion_control
  import adc_pkg::*;
#(
  parameter int NUM_CHANNELS = `MAX_CHANNELS,
  parameter int RC_DIV = `RC_DIV_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic sleep_in,
  input wire logic comparator_in,
  output logic sample_hold_out,
  output logic [`RESULT_BITS-1:0] trial_code_out,
  output logic [`MAX_CHANNELS-1:0] channel_enable_out,
  output logic [`MAX_CHANNELS-1:0] analog_pin_enable_out,
  output logic high_ref_from_pin_out,
  output logic low_ref_from_pin_out,
  output logic converter_power_on_out,
  output logic conversion_busy_out,
  output logic irq_out
);
  // ****************************************
  // elaboration checks
  // ****************************************
  if (NUM_CHANNELS != 5 && NUM_CHANNELS != `MAX_CHANNELS) begin : g_check
    $error("NUM_CHANNELS must be 5 or 8");
  end

  // ****************************************
  // functions
  // ****************************************
  // channels above the fitted count do not exist
  function automatic logic [`MAX_CHANNELS-1:0] fitted_mask();
    logic [`MAX_CHANNELS-1:0] m;
    m = '0;
    for (int i = 0; i < `MAX_CHANNELS; i++) begin
      m[i] = (i < NUM_CHANNELS);
    end
    return m;
  endfunction

  function automatic logic [`MAX_CHANNELS-1:0] one_hot(
    input logic [2:0] idx
  );
    logic [`MAX_CHANNELS-1:0] v;
    v = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  function automatic logic [7:0] lane_mask(input logic [3:0] sel);
    return {8{sel[0]}};
  endfunction

  // ****************************************
  // state
  // ****************************************
  ctrl_state_type st_reg;
  ctrl_state_type st_next;
  conv_clock_type wr_clk;
  logic [5:0] idx;
  logic req;
  logic wr;
  logic ctrl_wr;
  logic [7:0] ctrl_byte;
  logic [7:0] ctrl_view;
  logic [1:0] events;
  logic [1:0] ref_mode;
  logic go_req;
  logic tick;
  logic [7:0] clear_bits;

  conv_if cif();

  // ****************************************
  // bus decode
  // ****************************************
  assign idx = wb_adr_in[7:2];
  assign req = wb_cyc_in && wb_stb_in;
  // a write lands on the edge where ack is seen high
  assign wr = req && wb_we_in && st_reg.ack;
  assign ctrl_wr = wr && wb_sel_in[0] && idx == `IDX_CONVERTER_CONTROL;
  assign ctrl_byte = wb_dat_in[7:0];
  assign wr_clk = conv_clock_type'(ctrl_byte[`CTRL_CLK_MSB:`CTRL_CLK_LSB]);
  assign go_req = ctrl_byte[`CTRL_GO_BIT] && ctrl_byte[`CTRL_ON_BIT];
  // only bits written as one on an enabled lane are cleared
  assign clear_bits = wb_dat_in[7:0] & lane_mask(wb_sel_in);

  // go reads high through the cycle where the result is stored
  always_comb begin
    ctrl_view = '0;
    ctrl_view[`CTRL_CLK_MSB:`CTRL_CLK_LSB] = st_reg.clk_sel;
    ctrl_view[`CTRL_CH_MSB:`CTRL_CH_LSB] = st_reg.ch_sel;
    ctrl_view[`CTRL_GO_BIT] = st_reg.busy;
    ctrl_view[`CTRL_ON_BIT] = st_reg.power_on;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.abort = 1'b0;
    st_next.finishing = 1'b0;
    events = '0;

    // wishbone: one wait cycle, registered ack and read data
    st_next.ack = req && !st_reg.ack;
    if (req && !st_reg.ack) begin
      st_next.dat = '0;
      unique case (idx)
        `IDX_CONVERTER_CONTROL: st_next.dat[7:0] = ctrl_view;
        `IDX_RESULT_HIGH:
          st_next.dat[1:0] = st_reg.result[`RESULT_BITS-1:8];
        `IDX_RESULT_LOW: st_next.dat[7:0] = st_reg.result[7:0];
        `IDX_PIN_FUNCTION_CONFIG:
          st_next.dat[`PIN_REF_MSB:0] = st_reg.pin_cfg;
        `IDX_INT_STATUS: st_next.dat[1:0] = st_reg.int_status;
        `IDX_INT_MASK: st_next.dat[1:0] = st_reg.int_mask;
        default: st_next.dat = '0;
      endcase
    end

    // control register write
    if (ctrl_wr) begin
      st_next.clk_sel = wr_clk;
      st_next.ch_sel = ctrl_byte[`CTRL_CH_MSB:`CTRL_CH_LSB];
      st_next.power_on = ctrl_byte[`CTRL_ON_BIT];
      if (!st_reg.busy && go_req) begin
        st_next.busy = 1'b1;
        st_next.start = 1'b1;
      end else if (st_reg.busy && !st_reg.finishing && !go_req) begin
        // clearing go or power mid conversion drops the result
        st_next.busy = 1'b0;
        st_next.abort = 1'b1;
        events[`INT_ABORT_BIT] = 1'b1;
      end
    end

    // pin configuration write, two byte lanes
    if (wr && idx == `IDX_PIN_FUNCTION_CONFIG) begin
      if (wb_sel_in[0]) begin
        st_next.pin_cfg[7:0] = wb_dat_in[7:0];
      end
      if (wb_sel_in[1]) begin
        st_next.pin_cfg[`PIN_REF_MSB:`PIN_REF_LSB] =
          wb_dat_in[`PIN_REF_MSB:`PIN_REF_LSB];
      end
    end

    // completion: result lands first, go clears one cycle later
    if (cif.done && st_reg.busy) begin
      st_next.result = cif.result;
      st_next.finishing = 1'b1;
      events[`INT_DONE_BIT] = 1'b1;
    end
    if (st_reg.finishing) begin
      st_next.busy = 1'b0;
    end

    if (wr && idx == `IDX_INT_MASK && wb_sel_in[0]) begin
      st_next.int_mask = wb_dat_in[1:0];
    end
    // set wins over a write-one-to-clear in the same cycle
    st_next.int_status = st_reg.int_status;
    if (wr && idx == `IDX_INT_STATUS && wb_sel_in[0]) begin
      st_next.int_status = st_reg.int_status & ~clear_bits[1:0];
    end
    st_next.int_status = st_next.int_status | events;

    // comparator arrives from the analog side, resynchronise
    st_next.comp_s1 = comparator_in;
    st_next.comp_s2 = st_reg.comp_s1;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg <= '0;
      st_reg.clk_sel <= CLK_DIV2;
      st_reg.pin_cfg <= `PIN_CFG_RESET;
      st_reg.int_status <= `INT_RESET;
      st_reg.int_mask <= `INT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // submodules
  // ****************************************
  assign cif.start = st_reg.start;
  assign cif.abort = st_reg.abort;
  assign cif.tick = tick;
  assign cif.comp = st_reg.comp_s2;

  conv_clock_gen #(
    .RC_DIV(RC_DIV)
  ) u_clock (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .clk_sel_in(st_reg.clk_sel),
    .power_on_in(st_reg.power_on),
    .sleep_in(sleep_in),
    .tick_out(tick)
  );

  sar_engine u_engine (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .cif(cif)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign ref_mode = st_reg.pin_cfg[`PIN_REF_MSB:`PIN_REF_LSB];
  // 00 rails, 01 high pin, 10 both pins, 11 low pin only
  assign high_ref_from_pin_out = ref_mode == 2'b01 ||
                                 ref_mode == 2'b10;
  assign low_ref_from_pin_out = ref_mode == 2'b10 ||
                                ref_mode == 2'b11;

  // a reference pin is forced analog whatever its own bit says
  always_comb begin
    analog_pin_enable_out = st_reg.pin_cfg[`PIN_ANALOG_MSB:0];
    if (high_ref_from_pin_out) begin
      analog_pin_enable_out[`HIGH_REF_CHANNEL] = 1'b1;
    end
    if (low_ref_from_pin_out) begin
      analog_pin_enable_out[`LOW_REF_CHANNEL] = 1'b1;
    end
    analog_pin_enable_out = analog_pin_enable_out & fitted_mask();
  end

  // mux stays open only while powered; absent channels never route
  assign channel_enable_out = st_reg.power_on ?
                              (one_hot(st_reg.ch_sel) & fitted_mask()) :
                              '0;
  assign sample_hold_out = cif.sampling;
  assign trial_code_out = cif.trial;
  assign converter_power_on_out = st_reg.power_on;
  assign conversion_busy_out = st_reg.busy;
  assign irq_out = |(st_reg.int_status & st_reg.int_mask);
  assign wb_ack_out = st_reg.ack;
  assign wb_dat_out = st_reg.dat;
endmodule

// *** test/adc_control_asserts.sv ***
// Purpose: port level checks of the converter control
// Assumes: bound into adc_conversion_control, one clock
// Notes: only design driven outputs are judged
`timescale 1ns/10ps
module adc_control_asserts #(
  parameter int NUM_CHANNELS = 8
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic sample_hold_out,
  input wire logic [9:0] trial_code_out,
  input wire logic [7:0] channel_enable_out,
  input wire logic [7:0] analog_pin_enable_out,
  input wire logic high_ref_from_pin_out,
  input wire logic low_ref_from_pin_out,
  input wire logic converter_power_on_out,
  input wire logic conversion_busy_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ****
  // bus
  // ****
  property p_ack_pulse;
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
  property p_ack_answer;
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack");
  property p_dat_hold;
    !wb_ack_out |-> $stable(wb_dat_out);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("dat moved");
  // ****
  // converter
  // ****
  property p_off_no_mux;
    !converter_power_on_out |-> channel_enable_out == 8'h00;
  endproperty
  a_off_no_mux: assert property (p_off_no_mux) else $error("mux on");
  property p_mux_onehot;
    converter_power_on_out |-> $onehot0(channel_enable_out);
  endproperty
  a_mux_onehot: assert property (p_mux_onehot) else $error("mux");
  property p_absent;
    1'b1 |-> (channel_enable_out >> NUM_CHANNELS) == 8'h00;
  endproperty
  a_absent: assert property (p_absent) else $error("absent ch");
  property p_ref_pins;
    (high_ref_from_pin_out |-> analog_pin_enable_out[3]) and
    (low_ref_from_pin_out |-> analog_pin_enable_out[2]);
  endproperty
  a_ref_pins: assert property (p_ref_pins) else $error("ref pin");
  // msb is always the first trial
  property p_msb_first;
    $past(trial_code_out) == 10'h000 && trial_code_out != 10'h000
      |-> trial_code_out == 10'h200;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("order");
  property p_sample_busy;
    $rose(sample_hold_out) |-> conversion_busy_out &&
      trial_code_out == 10'h000;
  endproperty
  a_sample_busy: assert property (p_sample_busy) else $error("smp");
  property p_conv_bounded;
    $rose(conversion_busy_out) |-> ##[1:1000] !conversion_busy_out;
  endproperty
  a_conv_bounded: assert property (p_conv_bounded) else $error("hung");
endmodule

// *** test/analog_front_model.sv ***
// Purpose: analog inputs and hold capacitor behind the mux
// Assumes: one level per channel, 10-bit scale
// Notes: comparator is high when held level >= trial code
`timescale 1ns/10ps
module analog_front_model (
  input wire logic ref_clk_in,
  input wire logic [7:0] channel_enable_in,
  input wire logic sample_hold_in,
  input wire logic [9:0] trial_code_in,
  input wire logic [79:0] levels_in,
  output logic comparator_out
);
  logic [9:0] held_reg = 10'h000;
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < 8; i++) begin
      if (sample_hold_in && channel_enable_in[i]) begin
        held_reg <= levels_in[i*10 +: 10];
      end
    end
  end
  // capacitor keeps the level once sampling ends
  assign comparator_out = (held_reg >= trial_code_in);
endmodule

// *** test/testbench.sv ***
// Purpose: self-checking bench of the converter control
// Assumes: classic Wishbone master, analog model on far side
// Notes: rc divide shortened to 4 cycles
`timescale 1ns/10ps
`include "adc_regs.svh"
`define CHECK(nm, exp, got) begin samples_checked++; \
  if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module testbench;
  import adc_pkg::*;
  localparam logic [7:0] ctl_adr = {`IDX_CONVERTER_CONTROL, 2'b00};
  localparam logic [7:0] hi_adr = {`IDX_RESULT_HIGH, 2'b00};
  localparam logic [7:0] lo_adr = {`IDX_RESULT_LOW, 2'b00};
  localparam logic [7:0] pin_adr = {`IDX_PIN_FUNCTION_CONFIG, 2'b00};
  localparam logic [7:0] sts_adr = {`IDX_INT_STATUS, 2'b00};
  localparam logic [7:0] msk_adr = {`IDX_INT_MASK, 2'b00};
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic sleep_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'h3;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd;
  logic [31:0] seed = 32'hd;
  logic wb_ack_out, comparator_in, sample_hold_out, irq_out;
  logic high_ref_from_pin_out, low_ref_from_pin_out;
  logic converter_power_on_out, conversion_busy_out;
  logic [9:0] trial_code_out, last;
  logic [7:0] channel_enable_out, analog_pin_enable_out;
  logic [7:0] small_mux, small_pins;
  logic [79:0] levels = '0;
  logic [95:0] tmp;
  logic [7:0] radr [6] = '{ctl_adr, hi_adr, lo_adr, pin_adr, sts_adr, 8'h00};
  int miscompares = 0, samples_checked = 0, cycles = 0;

  adc_conversion_control #(.NUM_CHANNELS(8), .RC_DIV(4))
    adc_conversion_control_inst (.ref_clk_in, .reset_n_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out,
    .wb_ack_out, .sleep_in, .comparator_in, .sample_hold_out,
    .trial_code_out, .channel_enable_out, .analog_pin_enable_out,
    .high_ref_from_pin_out, .low_ref_from_pin_out, .converter_power_on_out,
    .conversion_busy_out, .irq_out);
  // five channel variant on the same bus, only its mux and pin outputs are judged
  adc_conversion_control #(.NUM_CHANNELS(5), .RC_DIV(4))
    adc_conversion_control_small_inst (.ref_clk_in, .reset_n_in,
    .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
    .wb_dat_out(), .wb_ack_out(), .sleep_in, .comparator_in,
    .sample_hold_out(), .trial_code_out(), .channel_enable_out(small_mux),
    .analog_pin_enable_out(small_pins), .high_ref_from_pin_out(),
    .low_ref_from_pin_out(), .converter_power_on_out(),
    .conversion_busy_out(), .irq_out());
  analog_front_model analog_front_model_inst (.ref_clk_in,
    .channel_enable_in(channel_enable_out), .sample_hold_in(sample_hold_out),
    .trial_code_in(trial_code_out), .levels_in(levels),
    .comparator_out(comparator_in));

  always #50 ref_clk_in = ~ref_clk_in;
  // ****
  // helpers
  // ****
  task automatic close_out();
    $display("checked %0d wrong %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      close_out();
    end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] ctl(logic [1:0] c, logic [2:0] ch, logic g);
    return {24'h0, c, ch, g, 2'b01};
  endfunction
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    if (n >= 20) miscompares++;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (conversion_busy_out !== 1'b0 && n < 3000) begin
      @(posedge ref_clk_in);
      n++;
    end
    if (n >= 3000) miscompares++;
  endtask
  task automatic convert(input logic [1:0] c, input logic [2:0] ch);
    logic [9:0] lv;
    // levels was set by nonblocking assignment just before the call
    wb(1'b1, ctl_adr, ctl(c, ch, 1'b1));
    lv = levels[ch*10 +: 10];
    wb(1'b0, ctl_adr, 32'h0);
    `CHECK("go", 1'b1, rd[2])
    `CHECK("mux", 8'h01 << ch, channel_enable_out)
    `CHECK("small mux", ch < 5 ? 8'h01 << ch : 8'h00, small_mux)
    wait_idle();
    `CHECK("irq", 1'b1, irq_out)
    wb(1'b0, ctl_adr, 32'h0);
    `CHECK("control", ctl(c, ch, 1'b0), rd)
    wb(1'b0, hi_adr, 32'h0);
    `CHECK("high", {30'h0, lv[9:8]}, rd)
    wb(1'b0, lo_adr, 32'h0);
    `CHECK("low", {24'h0, lv[7:0]}, rd)
    wb(1'b1, sts_adr, 32'h1);
    @(posedge ref_clk_in);
    `CHECK("irq clear", 1'b0, irq_out)
  endtask
  // ****
  // sequence
  // ****
  initial begin
    repeat (4) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    foreach (radr[i]) begin
      wb(1'b0, radr[i], 32'h0);
      `CHECK("reset", 32'h0, rd)
    end
    wb(1'b1, msk_adr, 32'h3);
    wb(1'b1, ctl_adr, 32'hfb);
    wb(1'b0, ctl_adr, 32'h0);
    `CHECK("bit one", 32'hf9, rd)
    `CHECK("power", 1'b1, converter_power_on_out)
    wb(1'b1, ctl_adr, 32'h0);
    @(posedge ref_clk_in);
    `CHECK("mux off", 8'h00, channel_enable_out)
    wb(1'b1, pin_adr, 32'h200);
    @(posedge ref_clk_in);
    `CHECK("refs", 2'b11, {high_ref_from_pin_out, low_ref_from_pin_out})
    `CHECK("ref pins", 2'b11, analog_pin_enable_out[3:2])
    // upper lane only: low byte must survive
    wb_sel_in <= 4'h2;
    wb(1'b1, pin_adr, 32'h0f0);
    wb_sel_in <= 4'h3;
    wb(1'b0, pin_adr, 32'h0);
    `CHECK("lane", 32'h0, rd)
    wb(1'b1, pin_adr, 32'h0ff);
    @(posedge ref_clk_in);
    `CHECK("analog", 8'hff, analog_pin_enable_out)
    `CHECK("small pins", 8'h1f, small_pins)
    for (int k = 0; k < 8; k++) begin
      tmp = {xs(), xs(), xs()};
      if (k == 0) tmp[9:0] = 10'h000;
      if (k == 1) tmp[19:10] = 10'h3ff;
      levels <= tmp[79:0];
      convert(k[1:0], k[2:0]);
    end
    last = levels[79:70];
    wb(1'b1, ctl_adr, ctl(2'b10, 3'd5, 1'b1));
    repeat (20) @(posedge ref_clk_in);
    wb(1'b1, ctl_adr, ctl(2'b10, 3'd5, 1'b0));
    repeat (2) @(posedge ref_clk_in);
    `CHECK("abort", 1'b0, conversion_busy_out)
    wb(1'b0, sts_adr, 32'h0);
    `CHECK("abort flag", 32'h2, rd)
    wb(1'b0, hi_adr, 32'h0);
    `CHECK("kept", {30'h0, last[9:8]}, rd)
    wb(1'b1, sts_adr, 32'h2);
    // divided clock stops while asleep
    sleep_in <= 1'b1;
    wb(1'b1, ctl_adr, ctl(2'b01, 3'd6, 1'b1));
    repeat (200) @(posedge ref_clk_in);
    `CHECK("frozen", 1'b1, conversion_busy_out)
    sleep_in <= 1'b0;
    wait_idle();
    wb(1'b0, lo_adr, 32'h0);
    `CHECK("woken", {24'h0, levels[67:60]}, rd)
    wb(1'b1, sts_adr, 32'h1);
    sleep_in <= 1'b1;
    convert(2'b11, 3'd2);
    close_out();
  end
endmodule
bind adc_conversion_control adc_control_asserts #(
  .NUM_CHANNELS(NUM_CHANNELS)
) adc_control_asserts_inst (.ref_clk_in, .reset_n_in, .wb_cyc_in,
  .wb_stb_in, .wb_dat_out, .wb_ack_out, .sample_hold_out, .trial_code_out,
  .channel_enable_out, .analog_pin_enable_out, .high_ref_from_pin_out,
  .low_ref_from_pin_out, .converter_power_on_out, .conversion_busy_out);
